// ### core/fram_port_defs.vh
/*
 constants for the serial memory port: opcodes, status field positions,
 timing and array sizes. assumes plain verilog-2005 includers.
*/
// Contract
// - device active only while chip select low; serial clock path enabled then.
// - chip select high: standby, inputs ignored, serial output released.
// - input bits taken on rising clock, output bits change on falling clock.
// - any clock rate up to 20 MHz; clock may stop anywhere.
// - output driven only while returning read data, released during pause too.
// - protect pin low with protect-enable bit set refuses status writes.
// - pause low suspends operation, ignores clock and select; resumes when high.
// - each data byte committed at its eighth bit, no write delay.
// - array of 8192 byte locations, eight bits each.
// - spi modes 0 and 3 supported.
// - block protection of upper quarter, upper half or whole array.
// - write-disable command clears write-enable latch.
// - first byte after select is the opcode, then address and data.
// - unknown opcode: ignore input until next select fall, output released.
// - two-byte address msb first, low 13 bits used, top three ignored.
`ifndef FRAM_PORT_DEFS_VH
`define FRAM_PORT_DEFS_VH
`define CMD_SET_WRITE_LATCH 8'h06
`define CMD_CLEAR_WRITE_LATCH 8'h04
`define CMD_READ_STATUS 8'h05
`define CMD_WRITE_STATUS 8'h01
`define CMD_READ_MEM 8'h03
`define CMD_WRITE_MEM 8'h02
`define STAT_WEL_BIT 1
`define STAT_BP_LO 2
`define STAT_BP_HI 3
`define STAT_PROT_EN_BIT 7
`define STAT_RESET 8'h00
`define ADDR_W 13
`define MEM_DEPTH 8192
`define SCK_MAX_MHZ 20
`define CORE_MHZ 250
`define SCK_MIN_CORE_CYC ((`CORE_MHZ + `SCK_MAX_MHZ - 1) / `SCK_MAX_MHZ)
`endif

// ### core/pin_sync3.v
/*
 three-flop synchroniser for one pin; a change counts once the second and
 third stages agree. assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/10ps
module pin_sync3 #(
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // pin and filtered level
   input wire pin_i,
   output reg level_o
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         level_o <= RST_VAL;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_o <= s3_r;
         end
      end
   end
endmodule

// ### core/fram_spi_port.v
/*
 spi slave front end of an 8k x 8 memory with status register, write latch,
 block protection, pause and protect pins. assumes all pins are asynchronous
 to CORE_CLK_I, which runs at least 13x the serial clock (sync delay budget).
*/
`timescale 1ns/10ps
`include "fram_port_defs.vh"
module fram_spi_port (
   // clock and reset
   input wire CORE_CLK_I,
   input wire RST_I,
   // spi pins
   input wire CS_N_I,
   input wire SCK_I,
   input wire SI_I,
   output reg SO_O,
   output reg SO_OE_O,
   // control pins
   input wire WP_N_I,
   input wire HOLD_N_I
);
   localparam ST_OPC = 6'b000001;
   localparam ST_AHI = 6'b000010;
   localparam ST_ALO = 6'b000100;
   localparam ST_DAT = 6'b001000;
   localparam ST_STW = 6'b010000;
   localparam ST_IGN = 6'b100000;

   ////////////////////////////////////////////////////////////////////////
   wire cs_n;
   wire sck;
   wire si;
   wire wp_n;
   wire hold_n;
   wire [4:0] pins_raw = {CS_N_I, SCK_I, SI_I, WP_N_I, HOLD_N_I};
   wire [4:0] pins_syn;
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_sync
         // data and clock rest low like the edge detector, so no false edge follows reset
         pin_sync3 #(.RST_VAL((g == 2 || g == 3) ? 1'b0 : 1'b1)) u_sync (
            .clk_i(CORE_CLK_I),
            .rst_i(RST_I),
            .pin_i(pins_raw[g]),
            .level_o(pins_syn[g])
         );
      end
   endgenerate
   assign {cs_n, sck, si, wp_n, hold_n} = pins_syn;

   ////////////////////////////////////////////////////////////////////////
   // protected-region check for block protect field
   function prot_hit;
      input [1:0] bp;
      input [12:0] a;
      begin
         case (bp)
            2'b01: prot_hit = (a[12:11] == 2'b11);
            2'b10: prot_hit = a[12];
            2'b11: prot_hit = 1'b1;
            default: prot_hit = 1'b0;
         endcase
      end
   endfunction

   reg [7:0] mem [0:`MEM_DEPTH-1];
   reg sck_d_r;
   reg cs_d_r;
   reg [5:0] state_r;
   reg [7:0] opc_r;
   reg [7:0] sh_r;
   reg [2:0] cnt_r;
   reg [12:0] addr_r;
   reg [7:0] status_r;
   reg [7:0] tx_r;
   reg rd_act_r;
   reg wr_pend_r;
   reg [7:0] wr_data_r;
   reg [12:0] wr_addr_r;

   wire run = hold_n;
   wire sck_rise = run & ~cs_n & sck & ~sck_d_r;
   wire sck_fall = run & ~cs_n & ~sck & sck_d_r;
   wire cs_rise = run & cs_n & ~cs_d_r;
   wire cs_fall = run & ~cs_n & cs_d_r;
   wire [7:0] byte_in = {sh_r[6:0], si};
   wire byte_done = sck_rise & (cnt_r == 3'd7);
   wire [1:0] bp = status_r[`STAT_BP_HI:`STAT_BP_LO];
   wire wel = status_r[`STAT_WEL_BIT];

   ////////////////////////////////////////////////////////////////////////
   // byte commit one cycle on
   always @(posedge CORE_CLK_I) begin
      if (wr_pend_r) begin
         mem[wr_addr_r] <= wr_data_r;
      end
   end

   always @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
         state_r <= ST_OPC;
         opc_r <= 8'h00;
         sh_r <= 8'h00;
         cnt_r <= 3'd0;
         addr_r <= 13'h0000;
         status_r <= `STAT_RESET;
         tx_r <= 8'h00;
         rd_act_r <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_data_r <= 8'h00;
         wr_addr_r <= 13'h0000;
         SO_O <= 1'b0;
         SO_OE_O <= 1'b0;
      end else begin
         wr_pend_r <= 1'b0;
         if (run) begin
            sck_d_r <= sck;
            cs_d_r <= cs_n;
         end
         // drive only during read, not in pause
         SO_OE_O <= rd_act_r & ~cs_n & run;
         if (cs_rise || cs_fall) begin
            state_r <= ST_OPC;
            cnt_r <= 3'd0;
            rd_act_r <= 1'b0;
         end else if (sck_rise) begin
            sh_r <= byte_in;
            cnt_r <= cnt_r + 3'd1;
         end
         if (sck_fall && rd_act_r) begin
            SO_O <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
         end
         if (byte_done && !cs_rise && !cs_fall) begin
            case (state_r)
               ST_OPC: begin
                  opc_r <= byte_in;
                  case (byte_in)
                     `CMD_SET_WRITE_LATCH: begin
                        status_r[`STAT_WEL_BIT] <= 1'b1;
                        state_r <= ST_IGN;
                     end
                     `CMD_CLEAR_WRITE_LATCH: begin
                        status_r[`STAT_WEL_BIT] <= 1'b0;
                        state_r <= ST_IGN;
                     end
                     `CMD_READ_STATUS: begin
                        tx_r <= status_r;
                        rd_act_r <= 1'b1;
                        state_r <= ST_IGN;
                     end
                     `CMD_WRITE_STATUS: begin
                        state_r <= ST_STW;
                     end
                     `CMD_READ_MEM, `CMD_WRITE_MEM: begin
                        state_r <= ST_AHI;
                     end
                     default: begin
                        state_r <= ST_IGN;
                     end
                  endcase
               end
               ST_AHI: begin
                  addr_r[12:8] <= byte_in[4:0];
                  state_r <= ST_ALO;
               end
               ST_ALO: begin
                  addr_r[7:0] <= byte_in;
                  state_r <= ST_DAT;
                  if (opc_r == `CMD_READ_MEM) begin
                     tx_r <= mem[{addr_r[12:8], byte_in}];
                     rd_act_r <= 1'b1;
                     addr_r <= {addr_r[12:8], byte_in} + 13'd1;
                  end
               end
               ST_DAT: begin
                  addr_r <= addr_r + 13'd1;
                  if (opc_r == `CMD_READ_MEM) begin
                     tx_r <= mem[addr_r];
                  end else if (wel && !prot_hit(bp, addr_r)) begin
                     wr_pend_r <= 1'b1;
                     wr_data_r <= byte_in;
                     wr_addr_r <= addr_r;
                  end
               end
               ST_STW: begin
                  if (wel && !(~wp_n && status_r[`STAT_PROT_EN_BIT])) begin
                     status_r[`STAT_PROT_EN_BIT] <= byte_in[`STAT_PROT_EN_BIT];
                     status_r[`STAT_BP_HI:`STAT_BP_LO] <= byte_in[`STAT_BP_HI:`STAT_BP_LO];
                     status_r[`STAT_WEL_BIT] <= 1'b0;
                  end
                  state_r <= ST_IGN;
               end
               ST_IGN: begin
                  state_r <= ST_IGN;
               end
               default: begin
                  state_r <= ST_OPC;
               end
            endcase
         end
         // memory write clears latch at select rise
         if (cs_rise && opc_r == `CMD_WRITE_MEM && state_r == ST_DAT) begin
            status_r[`STAT_WEL_BIT] <= 1'b0;
         end
      end
   end
endmodule

// ### test/fram_spi_port_monitor.sv
/* pin checker for fram_spi_port.
   assumes one core clock domain and the bind below. */
`timescale 1ns/10ps
module fram_spi_monitor (
   input wire CORE_CLK_I,
   input wire RST_I,
   input wire CS_N_I,
   input wire SCK_I,
   input wire HOLD_N_I,
   input wire SO_O,
   input wire SO_OE_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   sequence desel_s; CS_N_I [*6]; endsequence
   sequence paused_s; !HOLD_N_I [*6]; endsequence
   chk_reset_quiet: assert property (disable iff (1'b0) RST_I |-> !SO_OE_O && !SO_O)
      else $error("pins busy in reset");
   chk_standby_quiet: assert property (desel_s |-> !SO_OE_O)
      else $error("driven while deselected");
   chk_pause_quiet: assert property (paused_s |-> !SO_OE_O)
      else $error("driven while paused");
   chk_abort_drop: assert property ($rose(CS_N_I) |-> ##[1:6] !SO_OE_O)
      else $error("enable kept after select rise");
   chk_pause_drop: assert property ($fell(HOLD_N_I) |-> ##[1:6] !SO_OE_O)
      else $error("enable kept after pause");
   chk_oe_in_frame: assert property ($rose(SO_OE_O) |-> !CS_N_I && HOLD_N_I)
      else $error("enable outside frame");
   chk_oe_drop_cause: assert property ($fell(SO_OE_O) |-> CS_N_I || !HOLD_N_I)
      else $error("enable dropped mid read");
   chk_so_after_fall: assert property (SO_OE_O && $past(SO_OE_O) && $changed(SO_O) |-> !SCK_I)
      else $error("output moved with clock high");
endmodule
bind fram_spi_port fram_spi_monitor fram_spi_monitor_inst (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
   .CS_N_I(CS_N_I), .SCK_I(SCK_I), .HOLD_N_I(HOLD_N_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O));

// ### test/spi_host_model.sv
/* spi host model: modes 0 and 3, 40 ns half period.
   assumes a 4 ns clk_i; clock and select stand still between frames. */
`timescale 1ns/10ps
module spi_host_model (
   input wire clk_i,
   input wire so_i,
   output reg cs_n_o = 1'b1,
   output reg sck_o = 1'b0,
   output reg si_o = 1'b0,
   output reg hold_n_o = 1'b1
);
   reg idle_r = 1'b0;
   task half;
      begin
         repeat (10) @(posedge clk_i);
         #1;
      end
   endtask
   task begin_frame(input m);
      begin
         idle_r = m;
         sck_o = m;
         half;
         cs_n_o = 1'b0;
         half;
      end
   endtask
   task xfer(input [7:0] tx, output [7:0] rx);
      integer k;
      begin
         for (k = 7; k >= 0; k = k - 1) begin
            sck_o = 1'b0;
            si_o = tx[k];
            half;
            sck_o = 1'b1;
            rx[k] = so_i;
            half;
         end
      end
   endtask
   task end_frame;
      begin
         sck_o = idle_r;
         half;
         cs_n_o = 1'b1;
         si_o = ~si_o;
         half;
      end
   endtask
   task pause;
      begin
         sck_o = 1'b0;
         half;
         hold_n_o = 1'b0;
         half;
         sck_o = 1'b1;
         half;
         sck_o = 1'b0;
         half;
         hold_n_o = 1'b1;
         half;
      end
   endtask
endmodule

// ### test/fram_spi_port_test.sv
/* bench for fram_spi_port driven by the spi host model.
   assumes a 4 ns core clock. */
`timescale 1ns/10ps
`include "fram_port_defs.vh"
`define H spi_host_model_inst
`define CK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module fram_spi_port_test;
   reg clk = 1'b0;
   reg rst = 1'b0;
   reg wp_n = 1'b1;
   reg md = 1'b0;
   reg [7:0] r;
   reg [7:0] ex [0:2];
   wire cs_n, sck, si, hold_n, so, oe;
   integer fail_count = 0;
   integer samples_checked = 0;
   integer bp, i;
   always #2 clk = ~clk;
   fram_spi_port fram_spi_port_inst (.CORE_CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck),
      .SI_I(si), .SO_O(so), .SO_OE_O(oe), .WP_N_I(wp_n), .HOLD_N_I(hold_n));
   spi_host_model spi_host_model_inst (.clk_i(clk), .so_i(oe ? so : ~so), .cs_n_o(cs_n),
      .sck_o(sck), .si_o(si), .hold_n_o(hold_n));
   task fr(input integer n, input [39:0] b);
      integer k;
      begin
         `H.begin_frame(md);
         for (k = n - 1; k >= 0; k = k - 1)
            `H.xfer(b[k*8 +: 8], r);
         `H.end_frame;
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      begin
         fr(1, `CMD_SET_WRITE_LATCH);
         fr(4, {`CMD_WRITE_MEM, a, d});
      end
   endtask
   task rd(input [15:0] a);
      fr(4, {`CMD_READ_MEM, a, 8'h00});
   endtask
   task sw(input [7:0] d);
      begin
         fr(1, `CMD_SET_WRITE_LATCH);
         fr(2, {`CMD_WRITE_STATUS, d});
      end
   endtask
   task t_wrap;
      begin
         fr(1, `CMD_SET_WRITE_LATCH);
         fr(5, {`CMD_WRITE_MEM, 16'hFFFF, 16'h5AA5});
         md = 1'b1;
         rd(16'h1FFF);
         `CK("wrap_hi", 8'h5A, r)
         rd(16'hE000);
         `CK("wrap_lo", 8'hA5, r)
         md = 1'b0;
         $display("t_wrap done");
      end
   endtask
   task t_latch;
      begin
         fr(1, `CMD_SET_WRITE_LATCH);
         fr(1, `CMD_CLEAR_WRITE_LATCH);
         fr(4, {`CMD_WRITE_MEM, 16'h0000, 8'h3C});
         rd(16'h0000);
         `CK("latch_clr", 8'hA5, r)
         fr(1, `CMD_SET_WRITE_LATCH);
         fr(5, {8'hFF, `CMD_WRITE_MEM, 16'h0000, 8'h77});
         fr(1, `CMD_SET_WRITE_LATCH);
         fr(3, {`CMD_WRITE_MEM, 16'h0000});
         rd(16'h0000);
         `CK("bad_op", 8'hA5, r)
         $display("t_latch done");
      end
   endtask
   task t_pause;
      begin
         `H.begin_frame(1'b0);
         `H.xfer(`CMD_READ_MEM, r);
         `H.xfer(8'h1F, r);
         `H.xfer(8'hFF, r);
         `H.pause;
         `H.xfer(8'h00, r);
         `H.end_frame;
         `CK("pause_rd", 8'h5A, r)
         $display("t_pause done");
      end
   endtask
   task t_lock;
      begin
         sw(8'h80);
         wp_n = 1'b0;
         sw(8'h0C);
         fr(2, {`CMD_READ_STATUS, 8'h00});
         `CK("stat_lock", 8'h80, r & 8'hFD)
         wp_n = 1'b1;
         sw(8'h00);
         fr(2, {`CMD_READ_STATUS, 8'h00});
         `CK("stat_free", 8'h00, r & 8'hFD)
         $display("t_lock done");
      end
   endtask
   task t_block;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            ex[i] = 8'hE0 + i;
            wr(16'h0FFF + i * 16'h0800, ex[i]);
         end
         for (bp = 1; bp < 4; bp = bp + 1) begin
            sw({4'h0, bp[1:0], 2'b00});
            for (i = 0; i < 3; i = i + 1) begin
               wr(16'h0FFF + i * 16'h0800, 8'h10 * bp + i);
               if (i + bp < 3)
                  ex[i] = 8'h10 * bp + i;
               rd(16'h0FFF + i * 16'h0800);
               `CK("block", ex[i], r)
            end
         end
         sw(8'h00);
         $display("t_block done");
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d failures %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #1 rst = 1'b1;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      repeat (8) @(posedge clk);
      `CK("oe_rst", 1'b0, oe)
      t_wrap;
      t_latch;
      t_pause;
      t_lock;
      t_block;
      tally_and_finish;
   end
   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      tally_and_finish;
   end
endmodule
